// ==== hdl/itod_pkg.sv ====
// Package: constants and state type of the interval timer and time-of-day block
package itod_pkg;

   localparam int unsigned ADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] TIMER_OFS     = 8'h00;
   localparam logic [7:0] CTRL_OFS      = 8'h04;
   localparam logic [7:0] EVT_OFS       = 8'h08;
   localparam logic [7:0] EVT_MASK_OFS  = 8'h0c;
   localparam logic [7:0] INT_CODE_OFS  = 8'h10;
   localparam logic [7:0] SET_HI_OFS    = 8'h14;
   localparam logic [7:0] SET_LO_OFS    = 8'h18;
   localparam logic [7:0] TOD_CMD_OFS   = 8'h1c;
   localparam logic [7:0] STORE_HI_OFS  = 8'h20;
   localparam logic [7:0] STORE_LO_OFS  = 8'h24;

   // Field positions
   localparam int unsigned CTRL_EXT_MASK_BIT = 0;
   localparam int unsigned CTRL_TMR_MASK_BIT = 1;
   localparam int unsigned EVT_TMR_NEG_BIT   = 0;
   localparam int unsigned EVT_SET_REF_BIT   = 1;
   localparam int unsigned CMD_SET_BIT       = 0;
   localparam int unsigned CMD_STORE_BIT     = 1;
   localparam int unsigned STAT_VALID_BIT    = 0;
   localparam int unsigned STAT_TMR_SW_BIT   = 1;
   localparam int unsigned STAT_TOD_SW_BIT   = 2;
   localparam int unsigned CODE_TMR_BIT      = 7;
   localparam int unsigned EVT_W             = 2;

   // Arithmetic units: bit 23 and bit 51 counted from the most significant end
   localparam logic [31:0] TIMER_UNIT    = 32'h0000_0100;
   localparam logic [63:0] TOD_UNIT      = 64'h0000_0000_0000_1000;
   localparam logic [63:0] TOD_KEEP_MASK = 64'hffff_ffff_ffff_f000;

   // Reset values
   localparam logic [31:0] TIMER_RST    = 32'h0000_0000;
   localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned TIMER_PERIOD_NS = 3300000;
   localparam int unsigned TOD_PERIOD_NS   = 1000;
   localparam int unsigned TIMER_TICK_CYCLES = TIMER_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TOD_TICK_CYCLES   = TOD_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_CNT_W = 17;
   localparam int unsigned US_CNT_W   = 5;

   typedef struct packed {
      logic [31:0]           timer;
      logic [TICK_CNT_W-1:0] tick_cnt;
      logic [US_CNT_W-1:0]   us_cnt;
      logic [63:0]           time_of_day;
      logic                  tod_valid;
      logic                  ext_mask;
      logic                  tmr_mask;
      logic [EVT_W-1:0]      evt;
      logic [EVT_W-1:0]      evt_mask;
      logic                  code_tmr;
      logic [31:0]           set_hi;
      logic [31:0]           set_lo;
      logic [31:0]           store_hi;
      logic [31:0]           store_lo;
      logic [31:0]           prdata;
      logic                  pslverr;
      logic                  tmr_sw_meta;
      logic                  tmr_sw;
      logic                  tod_sw_meta;
      logic                  tod_sw;
   } itod_state_t;

endpackage

// ==== hdl/itod_timer_clock.sv ====
// Module: interval timer word and time-of-day counter behind an APB slave
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Function
// RULE_01 - Decrement timer bit 23 every 3.3 ms
// RULE_02 - Positive-to-negative request, gated by two masks
// RULE_03 - Taken timer request sets code bit
// RULE_04 - Only upper 24 timer bits count
// RULE_05 - Written timer value decrements right after
// RULE_06 - Disabled switch: timer word plain storage
// RULE_07 - 64-bit counter adds at bit 51 per microsecond
// RULE_08 - Set discards operand bits 52 to 63
// RULE_09 - Stored value has bits 52-63 zero
// RULE_10 - Set acts only with panel switch enabled
// RULE_11 - Set replaces whole counter with operand
// RULE_12 - Store copies counter to storage doubleword
// RULE_13 - Counter ignores system reset and stops
// RULE_14 - Diagnostic test or power-off invalidates counter
// RULE_15 - Counting starts only after a set
// RULE_16 - Timer mask survives system reset
// RULE_17 - Decrement borrows upward, low bits untouched
// RULE_18 - Counter wraps silently on overflow
module itod_timer_clock #(
   parameter int unsigned TIMER_TICK = itod_pkg::TIMER_TICK_CYCLES
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [itod_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        timer_switch_normal,
   input  wire logic                        clock_set_panel_switch,
   input  wire logic                        system_reset,
   input  wire logic                        time_of_day_diag,
   output logic                             irq
);

   localparam int unsigned EVT_W_L      = itod_pkg::EVT_W;
   localparam int unsigned TICK_CNT_W_L = itod_pkg::TICK_CNT_W;
   localparam int unsigned US_CNT_W_L   = itod_pkg::US_CNT_W;

   itod_pkg::itod_state_t q;
   itod_pkg::itod_state_t n;

   logic        setup;
   logic        wr;
   logic        mapped;
   logic        timer_tick;
   logic        us_tick;
   logic        neg_ev;
   logic        refused_ev;
   logic        irq_tmr;
   logic        irq_ref;
   logic        set_cmd;
   logic        store_cmd;
   logic        wr_timer;
   logic [31:0] timer_dec;
   logic [31:0] rd_val;
   logic [EVT_W_L-1:0] evt_clr;

   // Zero wait states; every access completes in its first access cycle
   assign pready  = 1'b1;
   assign prdata  = q.prdata;
   assign pslverr = q.pslverr;
   assign irq     = irq_tmr | irq_ref;

   always_comb
   begin
      n          = q;
      setup      = psel & ~penable;
      wr         = psel & penable & pwrite;
      timer_tick = 1'b0;
      us_tick    = 1'b0;
      neg_ev     = 1'b0;
      refused_ev = 1'b0;
      set_cmd    = 1'b0;
      store_cmd  = 1'b0;
      wr_timer   = 1'b0;
      evt_clr    = '0;
      rd_val     = 32'h0000_0000;
      mapped     = 1'b1;

      // Panel switches are asynchronous to pclk
      n.tmr_sw_meta = timer_switch_normal;
      n.tmr_sw      = q.tmr_sw_meta;
      n.tod_sw_meta = clock_set_panel_switch;
      n.tod_sw      = q.tod_sw_meta;

      // Prescalers run free so a timer write never shifts the tick phase
      timer_tick = (q.tick_cnt == TICK_CNT_W_L'(TIMER_TICK - 1));
      n.tick_cnt = timer_tick ? '0 : q.tick_cnt + 1'b1;
      us_tick    = (q.us_cnt == US_CNT_W_L'(itod_pkg::TOD_TICK_CYCLES - 1));
      n.us_cnt   = us_tick ? '0 : q.us_cnt + 1'b1;

      // Interval timer word
      timer_dec = q.timer - itod_pkg::TIMER_UNIT; // see RULE_17
      if (q.tmr_sw && timer_tick) // see RULE_01
      begin
         n.timer = {timer_dec[31:8], q.timer[7:0]}; // see RULE_04
         neg_ev  = ~q.timer[31] & timer_dec[31]; // see RULE_02
      end
      wr_timer = wr && (paddr == itod_pkg::TIMER_OFS);
      if (wr_timer)
      begin
         // A write beats a coinciding tick; counting resumes on the next tick
         n.timer = pwdata; // see RULE_05 see RULE_06
      end

      // Time-of-day counter; system_reset deliberately not used here
      if (q.tod_valid && us_tick) // see RULE_15 see RULE_13
      begin
         n.time_of_day = q.time_of_day + itod_pkg::TOD_UNIT; // see RULE_07 see RULE_18
      end

      // Register writes
      if (wr)
      begin
         case (paddr)
            itod_pkg::CTRL_OFS:
            begin
               n.ext_mask = pwdata[itod_pkg::CTRL_EXT_MASK_BIT];
               n.tmr_mask = pwdata[itod_pkg::CTRL_TMR_MASK_BIT];
            end
            itod_pkg::EVT_OFS:      evt_clr    = pwdata[EVT_W_L-1:0];
            itod_pkg::EVT_MASK_OFS: n.evt_mask = pwdata[EVT_W_L-1:0];
            itod_pkg::SET_HI_OFS:   n.set_hi   = pwdata;
            itod_pkg::SET_LO_OFS:   n.set_lo   = pwdata;
            itod_pkg::TOD_CMD_OFS:
            begin
               set_cmd   = pwdata[itod_pkg::CMD_SET_BIT];
               store_cmd = pwdata[itod_pkg::CMD_STORE_BIT];
            end
            default:                n.set_lo   = q.set_lo;
         endcase
      end

      // Store samples the counter before any set in the same write
      if (store_cmd)
      begin
         {n.store_hi, n.store_lo} = q.time_of_day & itod_pkg::TOD_KEEP_MASK; // see RULE_12 see RULE_09
      end
      if (set_cmd)
      begin
         if (q.tod_sw) // see RULE_10
         begin
            n.time_of_day       = {q.set_hi, q.set_lo} & itod_pkg::TOD_KEEP_MASK; // see RULE_11 see RULE_08
            n.tod_valid = 1'b1; // see RULE_15
         end
         else
         begin
            refused_ev = 1'b1;
         end
      end

      // The diagnostic test destroys the value and stops counting
      if (time_of_day_diag)
      begin
         n.time_of_day       = 64'h0000_0000_0000_0000; // see RULE_14
         n.tod_valid = 1'b0; // see RULE_14
      end

      // System reset drops the master mask only
      if (system_reset)
      begin
         n.ext_mask = 1'b0; // see RULE_16
      end

      // Interrupt requests; the timer source needs both masks
      irq_tmr = q.evt[itod_pkg::EVT_TMR_NEG_BIT] & q.evt_mask[itod_pkg::EVT_TMR_NEG_BIT]
                & q.ext_mask & q.tmr_mask; // see RULE_02
      irq_ref = q.evt[itod_pkg::EVT_SET_REF_BIT] & q.evt_mask[itod_pkg::EVT_SET_REF_BIT];

      // Sticky events: a set in the same cycle outweighs the clear
      n.evt = (q.evt & ~evt_clr)
              | {refused_ev, neg_ev};
      // Clearing the event withdraws the request, so the code must not re-arm from it
      n.code_tmr = (q.code_tmr | irq_tmr) & ~evt_clr[itod_pkg::EVT_TMR_NEG_BIT]; // see RULE_03

      // Read data is captured in the setup cycle and held through access
      case (paddr)
         itod_pkg::TIMER_OFS:    rd_val = q.timer;
         itod_pkg::CTRL_OFS:
         begin
            rd_val[itod_pkg::CTRL_EXT_MASK_BIT] = q.ext_mask;
            rd_val[itod_pkg::CTRL_TMR_MASK_BIT] = q.tmr_mask;
         end
         itod_pkg::EVT_OFS:      rd_val[EVT_W_L-1:0] = q.evt;
         itod_pkg::EVT_MASK_OFS: rd_val[EVT_W_L-1:0] = q.evt_mask;
         itod_pkg::INT_CODE_OFS: rd_val[itod_pkg::CODE_TMR_BIT] = q.code_tmr;
         itod_pkg::SET_HI_OFS:   rd_val = q.set_hi;
         itod_pkg::SET_LO_OFS:   rd_val = q.set_lo;
         itod_pkg::TOD_CMD_OFS:
         begin
            rd_val[itod_pkg::STAT_VALID_BIT]  = q.tod_valid;
            rd_val[itod_pkg::STAT_TMR_SW_BIT] = q.tmr_sw;
            rd_val[itod_pkg::STAT_TOD_SW_BIT] = q.tod_sw;
         end
         itod_pkg::STORE_HI_OFS: rd_val = q.store_hi;
         itod_pkg::STORE_LO_OFS: rd_val = q.store_lo;
         default:                mapped = 1'b0;
      endcase
      if (setup)
      begin
         n.prdata  = mapped ? rd_val : 32'h0000_0000;
         n.pslverr = ~mapped;
      end
   end

   // presetn stands for power-on; it and time_of_day_diag are the only things that clear the counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q           <= '0;
         q.timer     <= itod_pkg::TIMER_RST;
         q.evt       <= itod_pkg::EVT_RST;
      end
      else
      begin
         q <= n;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   timer_dec_step_a: assert property ( // see RULE_01
      q.tmr_sw && timer_tick && !wr_timer |=> q.timer == $past(q.timer) - 32'h0000_0100)
      else $error("timer word not decremented by one unit at tick");

   timer_low_bits_a: assert property ( // see RULE_17
      !wr_timer |=> q.timer[7:0] == $past(q.timer[7:0]))
      else $error("timer low bits changed by counting");

   timer_disabled_a: assert property ( // see RULE_06
      !q.tmr_sw && !wr_timer |=> $stable(q.timer))
      else $error("timer word changed while switch disabled");

   timer_write_a: assert property ( // see RULE_05
      wr_timer |=> q.timer == $past(pwdata))
      else $error("timer write not stored");

   neg_event_a: assert property ( // see RULE_02
      q.tmr_sw && timer_tick && !wr_timer && !q.timer[31] && q.timer[31:8] == 24'h000000
      |=> q.evt[0])
      else $error("positive to negative transition not flagged");

   irq_gate_a: assert property ( // see RULE_02
      !(q.ext_mask && q.tmr_mask) && !(q.evt[1] && q.evt_mask[1]) |-> !irq)
      else $error("interrupt raised while timer masked");

   int_code_a: assert property ( // see RULE_03
      irq_tmr && !evt_clr[itod_pkg::EVT_TMR_NEG_BIT] |=> q.code_tmr)
      else $error("timer code bit not set when request taken");

   tod_low_zero_a: assert property ( // see RULE_08
      q.time_of_day[11:0] == 12'h000 && q.store_lo[11:0] == 12'h000)
      else $error("counter or stored value has low bits set");

   tod_count_a: assert property ( // see RULE_07
      q.tod_valid && us_tick && !set_cmd && !time_of_day_diag
      |=> q.time_of_day == $past(q.time_of_day) + 64'h0000_0000_0000_1000)
      else $error("counter did not advance one microsecond unit");

   tod_idle_a: assert property ( // see RULE_15
      !q.tod_valid && !set_cmd |=> $stable(q.time_of_day))
      else $error("counter moved before first set");

   set_gate_a: assert property ( // see RULE_10
      set_cmd && !q.tod_sw && !time_of_day_diag
      |=> q.evt[1] && q.tod_valid == $past(q.tod_valid))
      else $error("set acted while panel switch not enabled");

   store_copy_a: assert property ( // see RULE_12
      store_cmd |=> {q.store_hi, q.store_lo} == ($past(q.time_of_day) & 64'hffff_ffff_ffff_f000))
      else $error("store did not copy the counter");

   mask_keep_a: assert property ( // see RULE_16
      system_reset && !wr |=> q.tmr_mask == $past(q.tmr_mask) && !q.ext_mask)
      else $error("timer mask lost on system reset");

   diag_kill_a: assert property ( // see RULE_14
      time_of_day_diag |=> !q.tod_valid ##1 !q.tod_valid || $past(set_cmd))
      else $error("counter still valid after diagnostic");

   evt_clear_a: assert property ( // see RULE_02
      wr && paddr == itod_pkg::EVT_OFS && pwdata[itod_pkg::EVT_TMR_NEG_BIT] && !neg_ev
      |=> !q.evt[itod_pkg::EVT_TMR_NEG_BIT])
      else $error("timer event not cleared by writing one");

   ref_clear_a: assert property ( // see RULE_10
      wr && paddr == itod_pkg::EVT_OFS && pwdata[itod_pkg::EVT_SET_REF_BIT] && !refused_ev
      |=> !q.evt[itod_pkg::EVT_SET_REF_BIT])
      else $error("refused set event not cleared by writing one");

   evt_sticky_a: assert property ( // see RULE_02
      q.evt[itod_pkg::EVT_TMR_NEG_BIT] && !evt_clr[itod_pkg::EVT_TMR_NEG_BIT]
      |=> q.evt[itod_pkg::EVT_TMR_NEG_BIT])
      else $error("timer event dropped without a clear");

   neg_dec_only_a: assert property ( // see RULE_02
      !(q.tmr_sw && timer_tick) && !q.evt[itod_pkg::EVT_TMR_NEG_BIT]
      |=> !q.evt[itod_pkg::EVT_TMR_NEG_BIT])
      else $error("timer event raised without a decrement");

   code_clear_a: assert property ( // see RULE_03
      evt_clr[itod_pkg::EVT_TMR_NEG_BIT]
      |=> !q.code_tmr)
      else $error("interruption code bit not cleared with its event");

   ctrl_write_a: assert property ( // see RULE_02
      wr && paddr == itod_pkg::CTRL_OFS && !system_reset
      |=> q.ext_mask == $past(pwdata[itod_pkg::CTRL_EXT_MASK_BIT])
          && q.tmr_mask == $past(pwdata[itod_pkg::CTRL_TMR_MASK_BIT]))
      else $error("mask bits not written");

   set_load_a: assert property ( // see RULE_11
      set_cmd && q.tod_sw && !time_of_day_diag
      |=> q.time_of_day == ($past({q.set_hi, q.set_lo}) & itod_pkg::TOD_KEEP_MASK) && q.tod_valid)
      else $error("set did not load the staged operand");

   reset_keep_a: assert property ( // see RULE_13
      system_reset && q.tod_valid && !set_cmd && !time_of_day_diag
      |=> q.tod_valid
          && q.time_of_day == $past(q.time_of_day) + ($past(us_tick) ? itod_pkg::TOD_UNIT : 64'h0))
      else $error("system reset disturbed the counter");

   tod_hold_a: assert property ( // see RULE_07
      !us_tick && !set_cmd && !time_of_day_diag
      |=> $stable(q.time_of_day))
      else $error("counter moved between microsecond ticks");

   tod_wrap_a: assert property ( // see RULE_18
      q.tod_valid && us_tick && !set_cmd && !time_of_day_diag
      && q.time_of_day == itod_pkg::TOD_KEEP_MASK
      |=> q.time_of_day == 64'h0000_0000_0000_0000 && q.tod_valid)
      else $error("counter did not wrap silently to zero");

   valid_keep_a: assert property ( // see RULE_13
      q.tod_valid && !time_of_day_diag
      |=> q.tod_valid)
      else $error("counter lost validity without diagnostic");

   valid_rise_a: assert property ( // see RULE_15
      !q.tod_valid && !(set_cmd && q.tod_sw)
      |=> !q.tod_valid)
      else $error("counter became valid without an enabled set");

   set_hold_a: assert property ( // see RULE_10
      set_cmd && !q.tod_sw && !us_tick && !time_of_day_diag
      |=> $stable(q.time_of_day))
      else $error("refused set changed the counter");

   bad_addr_a: assert property (
      psel && !penable && paddr[1:0] != 2'b00
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("misaligned access not refused");

   rd_hold_a: assert property (
      psel && penable
      |=> $stable(prdata) && $stable(pslverr))
      else $error("read data changed after the access cycle");

   irq_tmr_on_a: assert property ( // see RULE_02
      q.evt[itod_pkg::EVT_TMR_NEG_BIT] && q.evt_mask[itod_pkg::EVT_TMR_NEG_BIT]
      && q.ext_mask && q.tmr_mask
      |-> irq)
      else $error("unmasked timer event not presented");

   irq_ref_a: assert property ( // see RULE_10
      q.evt[itod_pkg::EVT_SET_REF_BIT] && q.evt_mask[itod_pkg::EVT_SET_REF_BIT]
      |-> irq)
      else $error("unmasked refused set event not presented");

endmodule // itod_timer_clock

`default_nettype wire

// ==== bench/itod_timer_clock_test.sv ====
// Self-checking testbench of the interval timer and time-of-day block
`timescale 1ns/10ps
`default_nettype none
module itod_timer_clock_test;
   localparam int unsigned TICK = 40; // Short timer tick keeps the run brief
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tsw     = 1'b0;
   logic        csw     = 1'b0;
   logic        sys_rst = 1'b0;
   logic        diag    = 1'b0;
   logic        irq;
   int          err_count  = 0;
   int          n_compared = 0;
   logic [31:0] rd;
   logic        perr;
   logic [63:0] st1;
   logic [63:0] st2;

   itod_timer_clock #(.TIMER_TICK(TICK)) itod_timer_clock_i (
      .pclk                   (pclk),
      .presetn                (presetn),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .timer_switch_normal    (tsw),
      .clock_set_panel_switch (csw),
      .system_reset           (sys_rst),
      .time_of_day_diag       (diag),
      .irq                    (irq)
   );

   always #25 pclk = ~pclk;

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Always three edges per transfer, so store spacing below is exact
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask

   // irq is combinational, so look at it mid-cycle where it has settled
   task automatic irqchk(input logic e);
      @(negedge pclk);
      chk(irq, e);
   endtask

   task automatic stor(output logic [63:0] v);
      apb(1'b1, itod_pkg::TOD_CMD_OFS, 32'h0000_0002);
      apb(1'b0, itod_pkg::STORE_HI_OFS, 32'h0000_0000);
      v[63:32] = rd;
      apb(1'b0, itod_pkg::STORE_LO_OFS, 32'h0000_0000);
      v[31:0] = rd;
   endtask

   task automatic t_reset;
      irqchk(1'b0);
      rchk(itod_pkg::TOD_CMD_OFS, 32'h0000_0000);
      rchk(itod_pkg::TIMER_OFS, 32'h0000_0000);
      apb(1'b0, 8'h28, 32'h0000_0000);
      chk({perr, rd}, {1'b1, 32'h0000_0000});
      apb(1'b1, 8'h02, 32'h0000_00ff);
      chk(perr, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_refused;
      apb(1'b1, itod_pkg::EVT_MASK_OFS, 32'h0000_0002);
      apb(1'b1, itod_pkg::SET_HI_OFS, 32'hffff_ffff);
      apb(1'b1, itod_pkg::SET_LO_OFS, 32'hffff_bfff);
      apb(1'b1, itod_pkg::TOD_CMD_OFS, 32'h0000_0001);
      rchk(itod_pkg::TOD_CMD_OFS, 32'h0000_0000);
      rchk(itod_pkg::EVT_OFS, 32'h0000_0002);
      irqchk(1'b1);
      apb(1'b1, itod_pkg::EVT_OFS, 32'h0000_0002);
      irqchk(1'b0);
      $display("test refused set done");
   endtask

   task automatic t_tod;
      @(posedge pclk);
      csw <= 1'b1;
      apb(1'b1, itod_pkg::CTRL_OFS, 32'h0000_0003);
      apb(1'b1, itod_pkg::TOD_CMD_OFS, 32'h0000_0001);
      stor(st1);
      chk(st1[11:0], 12'h000);
      chk((st1 - 64'hffff_ffff_ffff_b000) <= 64'h1000, 1'b1);
      rchk(itod_pkg::TOD_CMD_OFS, 32'h0000_0005);
      repeat (90) @(posedge pclk);
      sys_rst <= 1'b1;
      @(posedge pclk);
      sys_rst <= 1'b0;
      repeat (97) @(posedge pclk);
      stor(st2);
      chk(st2, st1 + 64'h0000_0000_0000_a000);
      rchk(itod_pkg::CTRL_OFS, 32'h0000_0002);
      diag <= 1'b1;
      @(posedge pclk);
      diag <= 1'b0;
      stor(st1);
      chk(st1, 64'h0);
      repeat (60) @(posedge pclk);
      stor(st1);
      chk(st1, 64'h0);
      csw <= 1'b0;
      $display("test time of day done");
   endtask

   task automatic t_timer;
      int n;
      tsw <= 1'b1;
      apb(1'b1, itod_pkg::CTRL_OFS, 32'h0000_0003);
      apb(1'b1, itod_pkg::EVT_MASK_OFS, 32'h0000_0001);
      apb(1'b1, itod_pkg::TIMER_OFS, 32'h8000_0000);
      rchk(itod_pkg::EVT_OFS, 32'h0000_0000);
      apb(1'b1, itod_pkg::TIMER_OFS, 32'h0000_0180);
      n = 0;
      do
      begin
         apb(1'b0, itod_pkg::TIMER_OFS, 32'h0000_0000);
         n++;
      end
      while (rd === 32'h0000_0180 && n < 30);
      chk(rd, 32'h0000_0080);
      n = 0;
      do
      begin
         apb(1'b0, itod_pkg::TIMER_OFS, 32'h0000_0000);
         n++;
      end
      while (rd === 32'h0000_0080 && n < 30);
      chk(rd, 32'hffff_ff80);
      irqchk(1'b1);
      rchk(itod_pkg::INT_CODE_OFS, 32'h0000_0080);
      apb(1'b1, itod_pkg::CTRL_OFS, 32'h0000_0002);
      irqchk(1'b0);
      apb(1'b1, itod_pkg::CTRL_OFS, 32'h0000_0003);
      apb(1'b1, itod_pkg::EVT_OFS, 32'h0000_0001);
      irqchk(1'b0);
      rchk(itod_pkg::INT_CODE_OFS, 32'h0000_0000);
      tsw <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b1, itod_pkg::TIMER_OFS, 32'h1234_5678);
      repeat (100) @(posedge pclk);
      rchk(itod_pkg::TIMER_OFS, 32'h1234_5678);
      $display("test timer done");
   endtask

   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_refused();
      t_tod();
      t_timer();
      close_out();
   end

   // The tests need under 2000 cycles; this span is many times that
   initial
   begin
      #1000000;
      err_count++;
      close_out();
   end
endmodule // itod_timer_clock_test
`default_nettype wire
